// ===== otc_pkg.sv
package otc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NCH = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_SETW = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RESP = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_BANK = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_NVCNT = 8'h14;

  // Field positions
  localparam int CMD_CODE_LSB = 8;
  localparam int CMD_INFO_LSB = 0;
  localparam int SETW_PORTA_BIT = 0;
  localparam int SETW_RT_BIT = 1;
  localparam int STAT_POLICY_BIT = 0;
  localparam int STAT_NVPEND_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_RUN_LSB = 4;
  localparam int STAT_MAN_LSB = 8;
  localparam int STAT_AT40_LSB = 12;
  localparam int STAT_AT100_LSB = 16;
  localparam int STAT_RSP_LSB = 20;

  // Command codes
  localparam logic [7:0] CMD_WMODE = 8'h04;
  localparam logic [7:0] CMD_SRST = 8'h06;
  localparam logic [7:0] CMD_RUN = 8'h0a;
  localparam logic [7:0] CMD_STOP = 8'h0b;
  localparam logic [7:0] CMD_MAN = 8'h0c;
  localparam logic [7:0] CMD_AUTO = 8'h0d;
  localparam logic [7:0] CMD_AT40 = 8'h0e;
  localparam logic [7:0] CMD_AT100 = 8'h0f;
  localparam logic [7:0] CMD_ATCAN = 8'h10;
  localparam logic [7:0] CMD_BANK0 = 8'h1e;
  localparam logic [7:0] CMD_BANK3 = 8'h21;
  localparam logic [7:0] CMD_LSP = 8'h22;
  localparam logic [7:0] CMD_RSP = 8'h23;
  localparam logic [7:0] CMD_ERST = 8'h2d;
  localparam logic [7:0] CMD_ALM1 = 8'h32;
  localparam logic [7:0] CMD_ALM3 = 8'h34;
  localparam logic [7:0] CMD_ALMALL = 8'h35;
  localparam logic [7:0] CMD_SAVE = 8'h37;
  localparam logic [7:0] CMD_PINIT = 8'h38;
  localparam logic [7:0] CMD_SAVE2 = 8'h39;
  localparam logic [7:0] CMD_UCFG = 8'h3b;

  localparam logic [7:0] INFO_ZERO = 8'h00;
  localparam logic [7:0] INFO_ONE = 8'h01;
  localparam logic [7:0] INFO_ALL = 8'hff;

  // Response codes
  localparam logic [15:0] RSP_OK = 16'h0000;
  localparam logic [15:0] RSP_PARAM = 16'h1100;
  localparam logic [15:0] RSP_STOPPED = 16'h2202;
  localparam logic [15:0] RSP_NVBUSY = 16'h7014;
  localparam logic [15:0] RSP_MANUAL = 16'h7041;
  localparam logic [15:0] RSP_TUNING = 16'h7042;

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // Nonvolatile write time
  localparam int CLK_NS = 8;
  localparam int NV_WRITE_NS = 1000;
  localparam int NV_WRITE_CYC = (NV_WRITE_NS + CLK_NS - 1) / CLK_NS;

  localparam logic POLICY_RAM_RST = 1'b1;

  typedef enum logic [1:0] {NV_SETTING, NV_MV, NV_RUNTIME, NV_ALL} otc_nv_kind_t;

  typedef struct packed {
    logic policy_ram;
    logic nv_pending;
    logic [NCH-1:0] run;
    logic [NCH-1:0] manual;
    logic [NCH-1:0] at40;
    logic [NCH-1:0] at100;
    logic [NCH-1:0] rsp;
    logic [2*NCH-1:0] bank;
    logic [15:0] resp;
    logic soft_rst;
    logic err_rst;
    logic pinit;
    logic ucfg_rst;
    logic ucfg_reg;
    logic [3*NCH-1:0] alm_clr;
    logic nv_req;
    otc_nv_kind_t nv_kind;
  } otc_dev_t;

  localparam otc_dev_t DEV_RST = '{policy_ram: POLICY_RAM_RST, nv_kind: NV_SETTING, default: '0};

endpackage

// ===== otc_nv_if.sv
`timescale 1ns/1ps
interface otc_nv_if;
  import otc_pkg::*;
  logic req;
  otc_nv_kind_t kind;
  logic busy;
  logic [15:0] commits;
  modport ctl (output req, output kind, input busy, input commits);
  modport mem (input req, input kind, output busy, output commits);
endinterface

// ===== otc_nv_writer.sv
`timescale 1ns/1ps
module otc_nv_writer import otc_pkg::*; #(
  parameter int WRITE_CYC = NV_WRITE_CYC
) (
  input wire logic aclk,     // Clock
  input wire logic aresetn,  // Sync reset, low
  otc_nv_if.mem nv           // Commit requests
);

  typedef struct packed {
    logic busy;
    logic [15:0] cnt;
    logic [15:0] commits;
  } otc_nvw_t;

  otc_nvw_t st_reg;
  otc_nvw_t st_next;

  always_comb begin
    st_next = st_reg;
    if (nv.req && !st_reg.busy) begin
      st_next.busy = 1'b1;
      st_next.cnt = 16'(WRITE_CYC - 1);
      st_next.commits = st_reg.commits + 16'h0001;
    end else if (st_reg.busy) begin
      if (st_reg.cnt == 16'h0000) begin
        st_next.busy = 1'b0;
      end else begin
        st_next.cnt = st_reg.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign nv.busy = st_reg.busy;
  assign nv.commits = st_reg.commits;

endmodule

// ===== otc_cmd_handler.sv
// Overview of operation
// - Code 04 sets write policy; info 00 backup, 01 RAM write.
// - Write policy comes up in RAM write mode after reset.
// - Backup mode commits every secondary-port setting to nonvolatile memory.
// - RAM mode still commits parameters changeable only when stopped or reset.
// - RAM mode keeps run-time parameters in RAM only; power cycle restores them.
// - Switching RAM to backup mode does not flush run-time parameters.
// - Primary-port settings always commit to nonvolatile memory.
// - Gateway writes arrive on the secondary port and follow the policy.
// - Nonvolatile status indication is off after starting from stored values.
// - Code 06 software reset acts like a full power cycle.
// - Run 0A, stop 0B; info 00-03 one channel, FF all.
// - Manual 0C, auto 0D; auto to manual stores manipulated output.
// - Code 37 with info FF saves run-time changeable values.
// - Code 39 with info FF saves all setting values.
// - Autotuning 0E at 40%, 0F at 100%, 10 cancels, per channel.
// - Banks via 1E-21, local setpoint 22, remote setpoint 23, per channel.
// - Alarm latch cancel 32-34 per alarm, 35 all, per channel.
// - Error reset 2D, initialization 38 with info 00; 3B 00/01.
// - Invalid code or related information answers parameter error.
// - Commands during a nonvolatile write answer the busy code.
// - Requesting the mode already held still completes normally.
// - Successful commands answer normal completion.
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module otc_cmd_handler import otc_pkg::*; (
  input wire logic aclk,                        // Clock
  input wire logic aresetn,                     // Sync reset, low
  input wire logic [ADDR_W-1:0] s_axi_awaddr,   // Write address
  input wire logic [2:0] s_axi_awprot,          // Unused
  input wire logic s_axi_awvalid,               // Write address valid
  output logic s_axi_awready,                   // Write address ready
  input wire logic [DATA_W-1:0] s_axi_wdata,    // Write data
  input wire logic [3:0] s_axi_wstrb,           // Unused, full words
  input wire logic s_axi_wvalid,                // Write data valid
  output logic s_axi_wready,                    // Write data ready
  output logic [1:0] s_axi_bresp,               // Write response
  output logic s_axi_bvalid,                    // Write response valid
  input wire logic s_axi_bready,                // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr,   // Read address
  input wire logic [2:0] s_axi_arprot,          // Unused
  input wire logic s_axi_arvalid,               // Read address valid
  output logic s_axi_arready,                   // Read address ready
  output logic [DATA_W-1:0] s_axi_rdata,        // Read data
  output logic [1:0] s_axi_rresp,               // Read response
  output logic s_axi_rvalid,                    // Read valid
  input wire logic s_axi_rready,                // Read ready
  output logic soft_reset_pulse,                // Software reset done
  output logic error_reset_pulse,               // Clear error latches
  output logic [3*NCH-1:0] alarm_clear_pulse,   // Alarm latch clears, 3 per channel
  output logic param_init_pulse,                // Restore default settings
  output logic unit_cfg_reset_pulse,            // Unit configuration reset
  output logic unit_cfg_register_pulse          // Unit configuration register
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
    logic aw_full;
    logic w_full;
    logic [ADDR_W-1:0] aw_addr;
    logic [DATA_W-1:0] wdata;
    otc_dev_t dev;
  } otc_state_t;

  otc_state_t st_reg;
  otc_state_t st_next;

  otc_nv_if nv ();

  otc_nv_writer #(.WRITE_CYC(NV_WRITE_CYC)) u_nv (
    .aclk(aclk),
    .aresetn(aresetn),
    .nv(nv.mem)
  );

  // Channel selector decode: {valid, mask}
  function automatic logic [NCH:0] chan_sel(input logic [7:0] info);
    logic [NCH:0] r;
    r = '0;
    if (info == INFO_ALL) begin
      r = {1'b1, {NCH{1'b1}}};
    end else if (info < 8'(NCH)) begin
      r = {1'b1, NCH'(1) << info[1:0]};
    end
    return r;
  endfunction

  logic do_write;
  logic cmd_wr;
  logic setw_wr;
  logic busy_now;
  logic [7:0] code;
  logic [7:0] info;
  logic [NCH:0] sel;
  logic [NCH-1:0] m;
  logic [NCH-1:0] tuning;
  logic [2:0] amask;

  assign do_write = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;
  assign cmd_wr = do_write && (st_reg.aw_addr == OFF_CMD);
  assign setw_wr = do_write && (st_reg.aw_addr == OFF_SETW);
  // A request just issued counts as busy before the writer reports it
  assign busy_now = nv.busy || st_reg.dev.nv_req;
  assign code = st_reg.wdata[CMD_CODE_LSB +: 8];
  assign info = st_reg.wdata[CMD_INFO_LSB +: 8];
  assign sel = chan_sel(info);
  assign m = sel[NCH-1:0];
  assign tuning = st_reg.dev.at40 | st_reg.dev.at100;
  assign amask = (code == CMD_ALMALL) ? 3'h7 : 3'(3'h1 << (code - CMD_ALM1));

  always_comb begin
    st_next = st_reg;
    st_next.dev.soft_rst = 1'b0;
    st_next.dev.err_rst = 1'b0;
    st_next.dev.pinit = 1'b0;
    st_next.dev.ucfg_rst = 1'b0;
    st_next.dev.ucfg_reg = 1'b0;
    st_next.dev.alm_clr = '0;
    st_next.dev.nv_req = 1'b0;
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_full = 1'b1;
      st_next.wdata = s_axi_wdata;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end

    if (do_write) begin
      st_next.aw_full = 1'b0;
      st_next.w_full = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = AXI_OKAY;
      case (st_reg.aw_addr)
        OFF_CMD: begin
          st_next.dev.resp = RSP_OK;
          if (busy_now) begin
            st_next.dev.resp = RSP_NVBUSY;
          end else begin
            case (code)
              CMD_WMODE: begin
                // Policy change alone never flushes RAM values
                if (info == INFO_ZERO) st_next.dev.policy_ram = 1'b0;
                else if (info == INFO_ONE) st_next.dev.policy_ram = 1'b1;
                else st_next.dev.resp = RSP_PARAM;
              end
              CMD_SRST: begin
                if (info == INFO_ZERO) begin
                  st_next.dev = DEV_RST;
                  st_next.dev.soft_rst = 1'b1;
                end else begin
                  st_next.dev.resp = RSP_PARAM;
                end
              end
              CMD_RUN, CMD_STOP, CMD_MAN, CMD_AUTO, CMD_ATCAN: begin
                if (!sel[NCH]) begin
                  st_next.dev.resp = RSP_PARAM;
                end else if (code == CMD_RUN) begin
                  st_next.dev.run = st_reg.dev.run | m;
                end else if (code == CMD_STOP) begin
                  st_next.dev.run = st_reg.dev.run & ~m;
                end else if (code == CMD_MAN) begin
                  if ((m & ~st_reg.dev.manual) != '0) begin
                    st_next.dev.nv_req = 1'b1;
                    st_next.dev.nv_kind = NV_MV;
                  end
                  st_next.dev.manual = st_reg.dev.manual | m;
                  st_next.dev.at40 = st_reg.dev.at40 & ~m;
                  st_next.dev.at100 = st_reg.dev.at100 & ~m;
                end else if (code == CMD_AUTO) begin
                  st_next.dev.manual = st_reg.dev.manual & ~m;
                end else begin
                  st_next.dev.at40 = st_reg.dev.at40 & ~m;
                  st_next.dev.at100 = st_reg.dev.at100 & ~m;
                end
              end
              CMD_AT40, CMD_AT100: begin
                if (!sel[NCH]) begin
                  st_next.dev.resp = RSP_PARAM;
                end else if ((m & ~st_reg.dev.run) != '0) begin
                  st_next.dev.resp = RSP_STOPPED;
                end else if ((m & st_reg.dev.manual) != '0) begin
                  st_next.dev.resp = RSP_MANUAL;
                end else if (code == CMD_AT40) begin
                  if ((m & st_reg.dev.at100) != '0) st_next.dev.resp = RSP_TUNING;
                  else st_next.dev.at40 = st_reg.dev.at40 | m;
                end else begin
                  if ((m & st_reg.dev.at40) != '0) st_next.dev.resp = RSP_TUNING;
                  else st_next.dev.at100 = st_reg.dev.at100 | m;
                end
              end
              CMD_LSP, CMD_RSP: begin
                if (!sel[NCH]) begin
                  st_next.dev.resp = RSP_PARAM;
                end else if ((m & tuning) != '0) begin
                  st_next.dev.resp = RSP_TUNING;
                end else if (code == CMD_LSP) begin
                  st_next.dev.rsp = st_reg.dev.rsp & ~m;
                end else begin
                  st_next.dev.rsp = st_reg.dev.rsp | m;
                end
              end
              CMD_ERST: begin
                if (info == INFO_ZERO) st_next.dev.err_rst = 1'b1;
                else st_next.dev.resp = RSP_PARAM;
              end
              CMD_SAVE, CMD_SAVE2: begin
                if (info == INFO_ALL) begin
                  st_next.dev.nv_req = 1'b1;
                  st_next.dev.nv_kind = (code == CMD_SAVE) ? NV_RUNTIME : NV_ALL;
                  st_next.dev.nv_pending = 1'b0;
                end else begin
                  st_next.dev.resp = RSP_PARAM;
                end
              end
              CMD_PINIT: begin
                if (info == INFO_ZERO) st_next.dev.pinit = 1'b1;
                else st_next.dev.resp = RSP_PARAM;
              end
              CMD_UCFG: begin
                if (info == INFO_ZERO) st_next.dev.ucfg_rst = 1'b1;
                else if (info == INFO_ONE) st_next.dev.ucfg_reg = 1'b1;
                else st_next.dev.resp = RSP_PARAM;
              end
              default: begin
                if (code >= CMD_BANK0 && code <= CMD_BANK3 && sel[NCH]) begin
                  if ((m & tuning) != '0) begin
                    st_next.dev.resp = RSP_TUNING;
                  end else begin
                    for (int c = 0; c < NCH; c++) begin
                      if (m[c]) st_next.dev.bank[2*c +: 2] = 2'(code - CMD_BANK0);
                    end
                  end
                end else if (code >= CMD_ALM1 && code <= CMD_ALMALL && sel[NCH]) begin
                  for (int c = 0; c < NCH; c++) begin
                    if (m[c]) st_next.dev.alm_clr[3*c +: 3] = amask;
                  end
                end else begin
                  st_next.dev.resp = RSP_PARAM;
                end
              end
            endcase
          end
        end
        OFF_SETW: begin
          st_next.dev.resp = RSP_OK;
          if (busy_now) begin
            st_next.dev.resp = RSP_NVBUSY;
          end else if (st_reg.wdata[SETW_PORTA_BIT] || !st_reg.dev.policy_ram
                       || !st_reg.wdata[SETW_RT_BIT]) begin
            st_next.dev.nv_req = 1'b1;
            st_next.dev.nv_kind = NV_SETTING;
          end else begin
            st_next.dev.nv_pending = 1'b1;
          end
        end
        OFF_RESP, OFF_STAT, OFF_BANK, OFF_NVCNT: begin
        end
        default: st_next.bresp = AXI_SLVERR;
      endcase
    end

    if (s_axi_arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = AXI_OKAY;
      st_next.rdata = '0;
      case (s_axi_araddr)
        OFF_CMD, OFF_SETW: begin
        end
        OFF_RESP: st_next.rdata[15:0] = st_reg.dev.resp;
        OFF_STAT: begin
          st_next.rdata[STAT_POLICY_BIT] = st_reg.dev.policy_ram;
          st_next.rdata[STAT_NVPEND_BIT] = st_reg.dev.nv_pending;
          st_next.rdata[STAT_BUSY_BIT] = busy_now;
          st_next.rdata[STAT_RUN_LSB +: NCH] = st_reg.dev.run;
          st_next.rdata[STAT_MAN_LSB +: NCH] = st_reg.dev.manual;
          st_next.rdata[STAT_AT40_LSB +: NCH] = st_reg.dev.at40;
          st_next.rdata[STAT_AT100_LSB +: NCH] = st_reg.dev.at100;
          st_next.rdata[STAT_RSP_LSB +: NCH] = st_reg.dev.rsp;
        end
        OFF_BANK: st_next.rdata[2*NCH-1:0] = st_reg.dev.bank;
        OFF_NVCNT: st_next.rdata[15:0] = nv.commits;
        default: st_next.rresp = AXI_SLVERR;
      endcase
    end

    st_next.awready = !st_next.aw_full && !st_next.bvalid;
    st_next.wready = !st_next.w_full && !st_next.bvalid;
    st_next.arready = !st_next.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '{dev: DEV_RST, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign nv.req = st_reg.dev.nv_req;
  assign nv.kind = st_reg.dev.nv_kind;

  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rdata = st_reg.rdata;
  assign soft_reset_pulse = st_reg.dev.soft_rst;
  assign error_reset_pulse = st_reg.dev.err_rst;
  assign alarm_clear_pulse = st_reg.dev.alm_clr;
  assign param_init_pulse = st_reg.dev.pinit;
  assign unit_cfg_reset_pulse = st_reg.dev.ucfg_rst;
  assign unit_cfg_register_pulse = st_reg.dev.ucfg_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_cmd_ok(logic [7:0] c);
    cmd_wr && !busy_now && code == c;
  endsequence

  sequence s_setw_ok;
    setw_wr && !busy_now;
  endsequence

  sequence s_nv_start(otc_nv_kind_t k);
    st_reg.dev.nv_req && st_reg.dev.nv_kind == k ##1 nv.busy;
  endsequence

  AST_POLICY_RST: assert property ($rose(aresetn) |-> st_reg.dev.policy_ram)
    else $error("write policy not RAM after reset");
  AST_WMODE: assert property (s_cmd_ok(CMD_WMODE) ##0 info == INFO_ZERO |=>
    !st_reg.dev.policy_ram && $stable(st_reg.dev.nv_pending) && !st_reg.dev.nv_req)
    else $error("backup policy not taken");
  AST_BACKUP_COMMIT: assert property (s_setw_ok ##0 !st_reg.dev.policy_ram |=> s_nv_start(NV_SETTING))
    else $error("backup mode write not committed");
  AST_RAM_STOPPED: assert property (s_setw_ok ##0 !st_reg.wdata[SETW_RT_BIT] |=> st_reg.dev.nv_req)
    else $error("stop-only parameter not committed");
  AST_RAM_ONLY: assert property (s_setw_ok ##0 st_reg.dev.policy_ram && st_reg.wdata[SETW_RT_BIT]
    && !st_reg.wdata[SETW_PORTA_BIT] |=> !st_reg.dev.nv_req && st_reg.dev.nv_pending)
    else $error("run-time parameter committed in RAM mode");
  AST_PORTA: assert property (s_setw_ok ##0 st_reg.wdata[SETW_PORTA_BIT] |=> s_nv_start(NV_SETTING))
    else $error("primary port write not committed");
  AST_BUSY: assert property ((cmd_wr || setw_wr) && busy_now |=>
    st_reg.dev.resp == RSP_NVBUSY && !st_reg.dev.nv_req && st_reg.bvalid)
    else $error("busy code not returned");
  AST_BADSAVE: assert property (s_cmd_ok(CMD_SAVE) ##0 info != INFO_ALL |=>
    st_reg.dev.resp == RSP_PARAM && !st_reg.dev.nv_req)
    else $error("bad save info accepted");
  AST_SAVE: assert property (s_cmd_ok(CMD_SAVE) ##0 info == INFO_ALL |=>
    !st_reg.dev.nv_pending && st_reg.dev.resp == RSP_OK ##0 s_nv_start(NV_RUNTIME))
    else $error("save run-time values failed");
  AST_MV: assert property (s_cmd_ok(CMD_MAN) ##0 sel[NCH] && (m & ~st_reg.dev.manual) != '0 |=>
    s_nv_start(NV_MV))
    else $error("manipulated output not stored");
  AST_ALL_RUN: assert property (s_cmd_ok(CMD_RUN) ##0 info == INFO_ALL |=>
    st_reg.dev.run == {NCH{1'b1}} && st_reg.dev.resp == RSP_OK)
    else $error("all-channel run incomplete");
  AST_SRST: assert property (s_cmd_ok(CMD_SRST) ##0 info == INFO_ZERO |=>
    soft_reset_pulse && st_reg.dev.policy_ram && st_reg.dev.run == '0 && !st_reg.dev.nv_pending
    ##1 !soft_reset_pulse)
    else $error("software reset incomplete");

endmodule

// ===== otc_host.sv
`timescale 1ns/1ps
module otc_host import otc_pkg::*; (
  input wire logic aclk // Clock
);
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

// ===== test_operation_command_handler.sv
`timescale 1ns/1ps
module test_operation_command_handler import otc_pkg::*; ();
  logic aclk, aresetn;
  logic [31:0] d;
  logic [1:0] r;
  wire [16:0] pl;
  logic [16:0] seen;
  int err_total, n_checks;
  otc_host i_host (.aclk(aclk));
  otc_cmd_handler i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(i_host.awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(i_host.awvalid), .s_axi_awready(i_host.awready), .s_axi_wdata(i_host.wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(i_host.wvalid), .s_axi_wready(i_host.wready), .s_axi_bresp(i_host.bresp),
    .s_axi_bvalid(i_host.bvalid), .s_axi_bready(i_host.bready), .s_axi_araddr(i_host.araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(i_host.arvalid), .s_axi_arready(i_host.arready),
    .s_axi_rdata(i_host.rdata), .s_axi_rresp(i_host.rresp), .s_axi_rvalid(i_host.rvalid),
    .s_axi_rready(i_host.rready), .soft_reset_pulse(pl[16]), .error_reset_pulse(pl[15]),
    .alarm_clear_pulse(pl[11:0]), .param_init_pulse(pl[14]), .unit_cfg_reset_pulse(pl[13]),
    .unit_cfg_register_pulse(pl[12]));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Sticky record of every pulse output
  always @(posedge aclk) seen <= aresetn ? (seen | pl) : '0;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] i, input logic [15:0] e);
    i_host.wr(OFF_CMD, {16'h0, c, i}, r);
    i_host.rd(OFF_RESP, d, r);
    chk(d, {16'h0, e});
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    i_host.rd(a, d, r);
    chk(d, e);
  endtask
  task automatic idle();
    do i_host.rd(OFF_STAT, d, r); while (d[STAT_BUSY_BIT] !== 1'b0);
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    tally_and_finish();
  end
  initial begin
    aresetn = 1'b0;
    err_total = 0;
    n_checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(OFF_STAT, 32'h1);
    cmd(CMD_RUN, 8'h02, RSP_OK);
    rdchk(OFF_STAT, 32'h41);
    cmd(CMD_RUN, INFO_ALL, RSP_OK);
    rdchk(OFF_STAT, 32'hf1);
    cmd(8'h05, 8'h00, RSP_PARAM);
    cmd(CMD_SRST, 8'h01, RSP_PARAM);
    cmd(CMD_SAVE, 8'h00, RSP_PARAM);
    cmd(CMD_STOP, 8'h04, RSP_PARAM);
    i_host.wr(OFF_SETW, 32'h2, r);
    rdchk(OFF_NVCNT, 32'h0);
    rdchk(OFF_STAT, 32'hf3);
    i_host.wr(OFF_SETW, 32'h0, r);
    rdchk(OFF_NVCNT, 32'h1);
    idle();
    cmd(CMD_WMODE, INFO_ZERO, RSP_OK);
    rdchk(OFF_NVCNT, 32'h1);
    rdchk(OFF_STAT, 32'hf2);
    i_host.wr(OFF_SETW, 32'h2, r);
    cmd(CMD_RUN, 8'h00, RSP_NVBUSY);
    idle();
    rdchk(OFF_NVCNT, 32'h2);
    cmd(CMD_WMODE, INFO_ONE, RSP_OK);
    i_host.wr(OFF_SETW, 32'h3, r);
    rdchk(OFF_NVCNT, 32'h3);
    idle();
    cmd(CMD_MAN, 8'h01, RSP_OK);
    rdchk(OFF_NVCNT, 32'h4);
    idle();
    cmd(CMD_MAN, 8'h01, RSP_OK);
    rdchk(OFF_NVCNT, 32'h4);
    cmd(CMD_AT40, 8'h01, RSP_MANUAL);
    cmd(CMD_AUTO, 8'h01, RSP_OK);
    cmd(CMD_AT40, 8'h01, RSP_OK);
    cmd(CMD_AT100, 8'h01, RSP_TUNING);
    cmd(CMD_BANK3, 8'h01, RSP_TUNING);
    cmd(CMD_ATCAN, 8'h01, RSP_OK);
    cmd(CMD_BANK3, 8'h01, RSP_OK);
    rdchk(OFF_BANK, 32'hc);
    cmd(CMD_RSP, 8'h01, RSP_OK);
    rdchk(OFF_STAT, 32'h2000f3);
    cmd(CMD_SAVE, INFO_ALL, RSP_OK);
    rdchk(OFF_STAT, 32'h2000f5);
    idle();
    cmd(CMD_SAVE2, INFO_ALL, RSP_OK);
    rdchk(OFF_NVCNT, 32'h6);
    idle();
    cmd(CMD_ALM1, 8'h02, RSP_OK);
    chk({20'h0, seen[11:0]}, 32'h40);
    cmd(CMD_ALMALL, INFO_ALL, RSP_OK);
    cmd(CMD_ERST, INFO_ZERO, RSP_OK);
    cmd(CMD_PINIT, INFO_ZERO, RSP_OK);
    cmd(CMD_UCFG, INFO_ZERO, RSP_OK);
    cmd(CMD_UCFG, INFO_ONE, RSP_OK);
    cmd(CMD_STOP, INFO_ALL, RSP_OK);
    cmd(CMD_SRST, INFO_ZERO, RSP_OK);
    chk({15'h0, seen}, 32'h1ffff);
    rdchk(OFF_STAT, 32'h1);
    i_host.rd(8'h40, d, r);
    chk({30'h0, r}, {30'h0, AXI_SLVERR});
    i_host.wr(8'h40, 32'h0, r);
    chk({30'h0, r}, {30'h0, AXI_SLVERR});
    tally_and_finish();
  end
endmodule
